// File: core/axil_reg_slave.sv
`timescale 1ns/1ps
module axil_reg_slave (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register bank side
  reg_access_if.slave ra
);
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_q;
  logic [7:0] w_q;
  logic w_lane0_q;

  assign awready = !aw_have_q && !bvalid;
  assign wready = !w_have_q && !bvalid;
  assign arready = !rvalid;

  // ****************************************
  // write path: address and data in any order
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end else if (aw_have_q && w_have_q) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_q <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end
    end
  end

  logic wr_ok;
  assign wr_ok = aw_q[7:2] < 6'(reset_value_pkg::NUM_REGS);
  // only byte lane 0 carries data; upper lanes are ignored
  assign ra.wr_en = aw_have_q && w_have_q && w_lane0_q && wr_ok;
  assign ra.wr_idx = aw_q[7:2];
  assign ra.wr_data = w_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= reset_value_pkg::RESP_OKAY;
    end else if (aw_have_q && w_have_q) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? reset_value_pkg::RESP_OKAY
                     : reset_value_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  assign ra.rd_idx = araddr[7:2];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= reset_value_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, ra.rd_data};
      rresp <= ra.rd_hit ? reset_value_pkg::RESP_OKAY
                         : reset_value_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// File: core/reg_access_if.sv
`timescale 1ns/1ps
interface reg_access_if;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic [5:0] rd_idx;
  logic [7:0] rd_data;
  logic rd_hit;
  modport slave (output wr_en, wr_idx, wr_data, rd_idx,
    input rd_data, rd_hit);
  modport bank (input wr_en, wr_idx, wr_data, rd_idx,
    output rd_data, rd_hit);
endinterface

// File: core/reset_value_bank.sv
`timescale 1ns/1ps
module reset_value_bank (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // reset and wake-up sources, already on aclk
  input wire logic power_on_rst,
  input wire logic brown_out_rst,
  input wire logic master_clear_pin_rst,
  input wire logic watchdog_timer_rst,
  input wire logic sleeping,
  input wire logic wake_watchdog,
  input wire logic wake_irq,
  input wire logic [7:0] wake_interrupt_control_reg_flags,
  input wire logic [7:0] wake_peripheral_flags_one_flags,
  input wire logic [7:0] wake_peripheral_flags_two_flags,
  // program counter low from the core, used for pc + 1
  input wire logic [7:0] pc_current,
  // register access
  reg_access_if.bank ra,
  // state views
  output logic [7:0] program_counter_low,
  output logic [7:0] status_reg,
  output logic [7:0] interrupt_control_reg,
  output logic [7:0] timer_two_period,
  output logic [1:0] last_event
);
  typedef logic [7:0] byte_type;
  byte_type regs_q [reset_value_pkg::NUM_REGS];
  reset_value_pkg::event_class_type cls;
  logic any_rst;

  // implemented-bit mask of each register
  function automatic byte_type impl_mask(input logic [5:0] idx);
    unique case (idx)
      reset_value_pkg::IDX_PORT_A_LATCH: impl_mask = reset_value_pkg::PORT_A_LATCH_MASK;
      reset_value_pkg::IDX_PROGRAM_COUNTER_HIGH_LATCH: impl_mask = reset_value_pkg::PROGRAM_COUNTER_HIGH_LATCH_MASK;
      reset_value_pkg::IDX_TIMER_ONE_CONTROL: impl_mask = reset_value_pkg::TIMER_ONE_CONTROL_MASK;
      reset_value_pkg::IDX_TIMER_TWO_CONTROL,
      reset_value_pkg::IDX_PERIPHERAL_FLAGS_ONE,
      reset_value_pkg::IDX_PERIPHERAL_ENABLES_ONE: impl_mask = reset_value_pkg::SEVEN_MASK;
      reset_value_pkg::IDX_RECEIVE_STATUS_CONTROL: impl_mask = reset_value_pkg::RECEIVE_STATUS_CONTROL_MASK;
      reset_value_pkg::IDX_CONVERTER_CONTROL_ZERO: impl_mask = reset_value_pkg::CONVERTER_CONTROL_ZERO_MASK;
      reset_value_pkg::IDX_PORT_A_DIRECTION: impl_mask = reset_value_pkg::PORT_A_LATCH_MASK;
      reset_value_pkg::IDX_PORT_E_DIRECTION: impl_mask = reset_value_pkg::PORT_E_DIRECTION_MASK;
      reset_value_pkg::IDX_EVENT: impl_mask = reset_value_pkg::EVENT_MASK;
      default: impl_mask = reset_value_pkg::ALL_ONES;
    endcase
  endfunction

  // ****************************************
  // event classification
  // ****************************************
  assign any_rst = power_on_rst || brown_out_rst || master_clear_pin_rst
                   || watchdog_timer_rst;
  always_comb begin
    if (power_on_rst || brown_out_rst) begin
      cls = reset_value_pkg::CLASS_POWER; // see [R18]
    end else if (master_clear_pin_rst || watchdog_timer_rst) begin
      cls = reset_value_pkg::CLASS_RESET;
    end else if (sleeping && (wake_watchdog || wake_irq)) begin
      cls = reset_value_pkg::CLASS_WAKE;
    end else begin
      cls = reset_value_pkg::CLASS_NONE;
    end
  end

  // ****************************************
  // register update
  // ****************************************
  // undefined power-on values are modelled as kept contents; the bus reset
  // alone brings every register to a known zero; see [R9]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < reset_value_pkg::NUM_REGS; i++) begin
        regs_q[i] <= reset_value_pkg::ZERO;
      end
    end else begin
      unique case (cls)
        reset_value_pkg::CLASS_POWER, reset_value_pkg::CLASS_RESET: begin
          regs_q[reset_value_pkg::IDX_PCL] <= reset_value_pkg::PC_RESET; // see [R2]
          regs_q[reset_value_pkg::IDX_OPTION] <= reset_value_pkg::ALL_ONES; // see [R5]
          regs_q[reset_value_pkg::IDX_PORT_A_DIRECTION] <= reset_value_pkg::PORT_A_LATCH_MASK;
          regs_q[reset_value_pkg::IDX_TRISB] <= reset_value_pkg::ALL_ONES;
          regs_q[reset_value_pkg::IDX_TRISC] <= reset_value_pkg::ALL_ONES;
          regs_q[reset_value_pkg::IDX_TRISD] <= reset_value_pkg::ALL_ONES;
          regs_q[reset_value_pkg::IDX_PORT_E_DIRECTION] <= reset_value_pkg::PORT_E_DIRECTION_RESET; // see [R6]
          regs_q[reset_value_pkg::IDX_PR2] <= reset_value_pkg::ALL_ONES; // see [R7]
          regs_q[reset_value_pkg::IDX_TIMER_TWO_COUNT] <= reset_value_pkg::ZERO; // see [R11]
          regs_q[reset_value_pkg::IDX_SERIAL_PORT_CONTROL] <= reset_value_pkg::ZERO;
          regs_q[reset_value_pkg::IDX_TRANSMIT_HOLDING] <= reset_value_pkg::ZERO;
          regs_q[reset_value_pkg::IDX_RECEIVE_HOLDING] <= reset_value_pkg::ZERO;
          regs_q[reset_value_pkg::IDX_CAP2CON] <= reset_value_pkg::ZERO;
          // bit 0 undefined, kept here
          regs_q[reset_value_pkg::IDX_RECEIVE_STATUS_CONTROL] <= regs_q[reset_value_pkg::IDX_RECEIVE_STATUS_CONTROL]
            & 8'h01; // see [R13]
          regs_q[reset_value_pkg::IDX_CONVERTER_CONTROL_ZERO] <= reset_value_pkg::ZERO; // see [R14]
          regs_q[reset_value_pkg::IDX_PROGRAM_COUNTER_HIGH_LATCH] <= reset_value_pkg::ZERO; // see [R15]
          regs_q[reset_value_pkg::IDX_TIMER_TWO_CONTROL] <= reset_value_pkg::ZERO; // see [R16]
          regs_q[reset_value_pkg::IDX_PERIPHERAL_FLAGS_ONE] <= reset_value_pkg::ZERO;
          regs_q[reset_value_pkg::IDX_PERIPHERAL_ENABLES_ONE] <= reset_value_pkg::ZERO;
          regs_q[reset_value_pkg::IDX_INTERRUPT_CONTROL_REG] <= regs_q[reset_value_pkg::IDX_INTERRUPT_CONTROL_REG]
            & reset_value_pkg::INTERRUPT_CONTROL_REG_KEEP; // see [R8]
          regs_q[reset_value_pkg::IDX_PORT_A_LATCH] <= regs_q[reset_value_pkg::IDX_PORT_A_LATCH]
            & reset_value_pkg::PORT_A_LATCH_KEEP; // see [R10]
          if (cls == reset_value_pkg::CLASS_POWER) begin
            regs_q[reset_value_pkg::IDX_STATUS] <= reset_value_pkg::STATUS_POR
              | (regs_q[reset_value_pkg::IDX_STATUS]
                 & reset_value_pkg::STATUS_KEEP_OTHER); // see [R4]
            regs_q[reset_value_pkg::IDX_TIMER_ONE_CONTROL] <= reset_value_pkg::ZERO; // see [R12]
          end else if (!watchdog_timer_rst && !sleeping) begin
            // clear while running leaves to and pd as they were
            regs_q[reset_value_pkg::IDX_STATUS] <=
              regs_q[reset_value_pkg::IDX_STATUS]
              & (reset_value_pkg::STATUS_KEEP_OTHER
                 | ~reset_value_pkg::STATUS_KEEP_WAKE); // see [R4]
          end else begin
            // to = watchdog not fired, pd = not asleep
            regs_q[reset_value_pkg::IDX_STATUS] <=
              (regs_q[reset_value_pkg::IDX_STATUS]
               & reset_value_pkg::STATUS_KEEP_OTHER)
              | (8'(!watchdog_timer_rst) << reset_value_pkg::STATUS_TO_BIT)
              | (8'(!sleeping) << reset_value_pkg::STATUS_PD_BIT); // see [R4]
          end
          regs_q[reset_value_pkg::IDX_EVENT] <= 8'(cls);
        end
        reset_value_pkg::CLASS_WAKE: begin
          // everything else retained; only flags, pc, status, period and event move
          if (wake_irq
              && regs_q[reset_value_pkg::IDX_INTERRUPT_CONTROL_REG][reset_value_pkg::GIE_BIT])
          begin
            regs_q[reset_value_pkg::IDX_PCL] <= reset_value_pkg::PC_VECTOR; // see [R1]
          end else begin
            regs_q[reset_value_pkg::IDX_PCL] <= pc_current + 8'h01; // see [R2]
          end
          regs_q[reset_value_pkg::IDX_INTERRUPT_CONTROL_REG] <= regs_q[reset_value_pkg::IDX_INTERRUPT_CONTROL_REG]
            | wake_interrupt_control_reg_flags; // see [R3]
          regs_q[reset_value_pkg::IDX_PERIPHERAL_FLAGS_ONE] <= regs_q[reset_value_pkg::IDX_PERIPHERAL_FLAGS_ONE]
            | (wake_peripheral_flags_one_flags & reset_value_pkg::SEVEN_MASK); // see [R3]
          regs_q[reset_value_pkg::IDX_PERIPHERAL_FLAGS_TWO] <= regs_q[reset_value_pkg::IDX_PERIPHERAL_FLAGS_TWO]
            | wake_peripheral_flags_two_flags;
          regs_q[reset_value_pkg::IDX_STATUS] <=
            (regs_q[reset_value_pkg::IDX_STATUS]
             & reset_value_pkg::STATUS_KEEP_WAKE)
            | (8'(!wake_watchdog) << reset_value_pkg::STATUS_TO_BIT); // see [R4]
          regs_q[reset_value_pkg::IDX_PR2] <= reset_value_pkg::ALL_ONES; // see [R7]
          regs_q[reset_value_pkg::IDX_EVENT] <= 8'(cls);
        end
        default: begin
          // software writes only between events; other registers retained
          if (ra.wr_en && ra.wr_idx != reset_value_pkg::IDX_EVENT) begin
            regs_q[ra.wr_idx] <= ra.wr_data & impl_mask(ra.wr_idx); // see [R17]
          end
        end
      endcase
    end
  end

  // ****************************************
  // reads and views
  // ****************************************
  always_comb begin
    ra.rd_hit = ra.rd_idx < 6'(reset_value_pkg::NUM_REGS);
    ra.rd_data = reset_value_pkg::ZERO;
    if (ra.rd_hit) begin
      ra.rd_data = regs_q[ra.rd_idx] & impl_mask(ra.rd_idx); // see [R17]
    end
  end

  assign program_counter_low = regs_q[reset_value_pkg::IDX_PCL];
  assign status_reg = regs_q[reset_value_pkg::IDX_STATUS];
  assign interrupt_control_reg = regs_q[reset_value_pkg::IDX_INTERRUPT_CONTROL_REG];
  assign timer_two_period = regs_q[reset_value_pkg::IDX_PR2];
  assign last_event = regs_q[reset_value_pkg::IDX_EVENT][1:0];

  // ****************************************
  // checks
  // ****************************************
  property p_vector;
    @(posedge aclk) disable iff (!aresetn)
    (cls == reset_value_pkg::CLASS_WAKE && wake_irq
     && interrupt_control_reg[reset_value_pkg::GIE_BIT])
    |=> program_counter_low == reset_value_pkg::PC_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("vector not loaded"); // see [R1]

  property p_pc_reset;
    @(posedge aclk) disable iff (!aresetn)
    any_rst |=> program_counter_low == reset_value_pkg::PC_RESET;
  endproperty
  a_pc_reset: assert property (p_pc_reset) else $error("pc not cleared"); // see [R2]

  property p_pc_step;
    @(posedge aclk) disable iff (!aresetn)
    (cls == reset_value_pkg::CLASS_WAKE && !wake_irq)
    |=> program_counter_low == $past(pc_current) + 8'h01;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc not advanced"); // see [R2]

  property p_status_por;
    @(posedge aclk) disable iff (!aresetn)
    (power_on_rst || brown_out_rst) |=> status_reg[7:3] == 5'h03;
  endproperty
  a_status_por: assert property (p_status_por) else $error("status bad"); // see [R4]

  property p_period;
    @(posedge aclk) disable iff (!aresetn)
    (cls != reset_value_pkg::CLASS_NONE) |=> timer_two_period == 8'hFF;
  endproperty
  a_period: assert property (p_period) else $error("period not set"); // see [R7]

  property p_interrupt_control_reg;
    @(posedge aclk) disable iff (!aresetn)
    any_rst |=> interrupt_control_reg[7:1] == 7'h00
      && interrupt_control_reg[0] == $past(interrupt_control_reg[0]);
  endproperty
  a_interrupt_control_reg: assert property (p_interrupt_control_reg) else $error("interrupt_control_reg bad"); // see [R8]

  property p_wake_flags;
    @(posedge aclk) disable iff (!aresetn)
    (cls == reset_value_pkg::CLASS_WAKE)
    |=> (interrupt_control_reg & $past(wake_interrupt_control_reg_flags))
        == $past(wake_interrupt_control_reg_flags);
  endproperty
  a_wake_flags: assert property (p_wake_flags) else $error("flag lost"); // see [R3]

  property p_event;
    @(posedge aclk) disable iff (!aresetn)
    (cls != reset_value_pkg::CLASS_NONE) |=> last_event == $past(2'(cls));
  endproperty
  a_event: assert property (p_event) else $error("class not kept"); // see [R18]
endmodule

// File: core/reset_value_loader.sv
`timescale 1ns/1ps
module reset_value_loader (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // event sources, same clock domain
  input wire logic power_on_rst,
  input wire logic brown_out_rst,
  input wire logic master_clear_pin_rst,
  input wire logic watchdog_timer_rst,
  input wire logic sleeping,
  input wire logic wake_watchdog,
  input wire logic wake_irq,
  input wire logic [7:0] wake_interrupt_control_reg_flags,
  input wire logic [7:0] wake_peripheral_flags_one_flags,
  input wire logic [7:0] wake_peripheral_flags_two_flags,
  input wire logic [7:0] pc_current,
  // state views
  output logic [7:0] program_counter_low,
  output logic [7:0] status_reg,
  output logic [7:0] interrupt_control_reg,
  output logic [7:0] timer_two_period,
  output logic [1:0] last_event
);
  reg_access_if ra ();

  axil_reg_slave u_slave (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ra(ra.slave)
  );

  reset_value_bank u_bank (
    .aclk(aclk), .aresetn(aresetn),
    .power_on_rst(power_on_rst), .brown_out_rst(brown_out_rst),
    .master_clear_pin_rst(master_clear_pin_rst),
    .watchdog_timer_rst(watchdog_timer_rst),
    .sleeping(sleeping), .wake_watchdog(wake_watchdog),
    .wake_irq(wake_irq), .wake_interrupt_control_reg_flags(wake_interrupt_control_reg_flags),
    .wake_peripheral_flags_one_flags(wake_peripheral_flags_one_flags), .wake_peripheral_flags_two_flags(wake_peripheral_flags_two_flags),
    .pc_current(pc_current), .ra(ra.bank),
    .program_counter_low(program_counter_low), .status_reg(status_reg),
    .interrupt_control_reg(interrupt_control_reg),
    .timer_two_period(timer_two_period), .last_event(last_event)
  );
endmodule

// File: core/reset_value_pkg.sv
// Function
// [R1] interrupt wake-up with global enable set loads program counter with 0004h.
// [R2] program counter cleared on every reset, advanced by one on wake-up.
// [R3] wake-up keeps registers; waking event sets flags in interrupt registers.
// [R4] status 0001 1xxx on power-on/brown-out; cause bits set on others.
// [R5] option and port A-D directions all ones on resets, kept on wake-up.
// [R6] port E direction 0000 -111 on all resets, kept on wake-up.
// [R7] timer two period set to all ones on every reset and wake-up.
// [R8] interrupt control 0000 000x on power-on, upper seven cleared on others.
// [R9] accumulator, timers, pointers, latches, captures undefined at power-on, kept after.
// [R10] port A 0x 0000 on power-on, 0u 0000 on master-clear or watchdog.
// [R11] timer two count, serial, holding, capture two control zeroed on resets.
// [R12] timer one control cleared only on power-on or brown-out reset.
// [R13] receive status 0000 -00x on every reset, kept on wake-up.
// [R14] converter control zero 0000 00-0 on every reset, kept on wake-up.
// [R15] five-bit program counter high latch cleared on every reset.
// [R16] timer two control, flags one, enables one -000 0000 on resets.
// [R17] unimplemented bits always read as zero.
// [R18] events sorted into three classes; matching column applied in one cycle.
package reset_value_pkg;

  // ****************************************
  // register indices (byte address = 4*idx)
  // ****************************************
  localparam logic [5:0] IDX_ACCUM = 6'h00;
  localparam logic [5:0] IDX_TIMER_ZERO_COUNT = 6'h01;
  localparam logic [5:0] IDX_PCL = 6'h02;
  localparam logic [5:0] IDX_STATUS = 6'h03;
  localparam logic [5:0] IDX_FSR = 6'h04;
  localparam logic [5:0] IDX_PORT_A_LATCH = 6'h05;
  localparam logic [5:0] IDX_PORT_B_LATCH = 6'h06;
  localparam logic [5:0] IDX_PORT_C_LATCH = 6'h07;
  localparam logic [5:0] IDX_PORT_D_LATCH = 6'h08;
  localparam logic [5:0] IDX_PROGRAM_COUNTER_HIGH_LATCH = 6'h09;
  localparam logic [5:0] IDX_INTERRUPT_CONTROL_REG = 6'h0A;
  localparam logic [5:0] IDX_PERIPHERAL_FLAGS_ONE = 6'h0B;
  localparam logic [5:0] IDX_PERIPHERAL_FLAGS_TWO = 6'h0C;
  localparam logic [5:0] IDX_TIMER_ONE_LOW = 6'h0D;
  localparam logic [5:0] IDX_TIMER_ONE_HIGH = 6'h0E;
  localparam logic [5:0] IDX_TIMER_ONE_CONTROL = 6'h0F;
  localparam logic [5:0] IDX_TIMER_TWO_COUNT = 6'h10;
  localparam logic [5:0] IDX_TIMER_TWO_CONTROL = 6'h11;
  localparam logic [5:0] IDX_SERIAL_PORT_CONTROL = 6'h12;
  localparam logic [5:0] IDX_CAP1L = 6'h13;
  localparam logic [5:0] IDX_CAP1H = 6'h14;
  localparam logic [5:0] IDX_RECEIVE_STATUS_CONTROL = 6'h15;
  localparam logic [5:0] IDX_TRANSMIT_HOLDING = 6'h16;
  localparam logic [5:0] IDX_RECEIVE_HOLDING = 6'h17;
  localparam logic [5:0] IDX_CAP2CON = 6'h18;
  localparam logic [5:0] IDX_CONVERSION_RESULT = 6'h19;
  localparam logic [5:0] IDX_CONVERTER_CONTROL_ZERO = 6'h1A;
  localparam logic [5:0] IDX_OPTION = 6'h1B;
  localparam logic [5:0] IDX_PORT_A_DIRECTION = 6'h1C;
  localparam logic [5:0] IDX_TRISB = 6'h1D;
  localparam logic [5:0] IDX_TRISC = 6'h1E;
  localparam logic [5:0] IDX_TRISD = 6'h1F;
  localparam logic [5:0] IDX_PORT_E_DIRECTION = 6'h20;
  localparam logic [5:0] IDX_PERIPHERAL_ENABLES_ONE = 6'h21;
  localparam logic [5:0] IDX_PR2 = 6'h22;
  localparam logic [5:0] IDX_EVENT = 6'h23;
  localparam int NUM_REGS = 36;

  // ****************************************
  // initial values and implemented-bit masks
  // ****************************************
  localparam logic [7:0] PC_RESET = 8'h00;
  localparam logic [7:0] PC_VECTOR = 8'h04;
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [7:0] STATUS_KEEP_OTHER = 8'h07;
  localparam logic [7:0] STATUS_KEEP_WAKE = 8'hE7;
  localparam int STATUS_TO_BIT = 4;
  localparam int STATUS_PD_BIT = 3;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ZERO = 8'h00;
  localparam logic [7:0] PORT_E_DIRECTION_RESET = 8'h07;
  localparam logic [7:0] PORT_E_DIRECTION_MASK = 8'hF7;
  localparam logic [7:0] INTERRUPT_CONTROL_REG_KEEP = 8'h01;
  localparam int GIE_BIT = 7;
  localparam logic [7:0] PORT_A_LATCH_MASK = 8'h3F;
  localparam logic [7:0] PORT_A_LATCH_KEEP = 8'h10;
  localparam logic [7:0] TIMER_ONE_CONTROL_MASK = 8'h3F;
  localparam logic [7:0] RECEIVE_STATUS_CONTROL_MASK = 8'hF7;
  localparam logic [7:0] CONVERTER_CONTROL_ZERO_MASK = 8'hFD;
  localparam logic [7:0] PROGRAM_COUNTER_HIGH_LATCH_MASK = 8'h1F;
  localparam logic [7:0] SEVEN_MASK = 8'h7F;
  localparam logic [7:0] EVENT_MASK = 8'h07;

  // ****************************************
  // axi responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CLASS_NONE,
    CLASS_POWER,
    CLASS_RESET,
    CLASS_WAKE
  } event_class_type;

endpackage

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pc_current = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, last_event;
  logic [31:0] rdata;
  logic power_on_rst = 1'b0, brown_out_rst = 1'b0, sleeping = 1'b0;
  logic master_clear_pin_rst = 1'b0, watchdog_timer_rst = 1'b0;
  logic wake_watchdog = 1'b0, wake_irq = 1'b0;
  logic [7:0] wake_interrupt_control_reg_flags = 8'h00, wake_peripheral_flags_one_flags = 8'h00;
  logic [7:0] wake_peripheral_flags_two_flags = 8'h00;
  logic [7:0] program_counter_low, status_reg, interrupt_control_reg;
  logic [7:0] timer_two_period;
  int fail_count = 0, comparisons = 0, cycles = 0;

  reset_value_loader u_dut (.*);

  always #12.5 aclk = ~aclk;

  // ****************
  // bus tasks
  // ****************
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (a || w) begin
      @(posedge aclk);
      if (a && awready === 1'b1) begin a = 1'b0; awvalid <= 1'b0; end
      if (w && wready === 1'b1) begin w = 1'b0; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] i, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rc(input logic [5:0] i, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(i, d, r);
    chk("rdata", {24'h0, e}, d);
  endtask

  // order: power, brown-out, clear, watchdog, wake irq, wake watchdog
  task automatic pulse(input logic [5:0] m);
    {power_on_rst, brown_out_rst, master_clear_pin_rst,
     watchdog_timer_rst, wake_irq, wake_watchdog} <= m;
    @(posedge aclk);
    {power_on_rst, brown_out_rst, master_clear_pin_rst,
     watchdog_timer_rst, wake_irq, wake_watchdog} <= 6'h00;
    repeat (2) @(posedge aclk);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard, the whole sequence needs well under 3000 cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ****************
  // tests
  // ****************
  logic [5:0] mi [5] = '{6'h20, 6'h1A, 6'h09, 6'h15, 6'h11};
  logic [7:0] me [5] = '{8'hF7, 8'hFD, 8'h1F, 8'hF7, 8'h7F};
  logic [31:0] d;
  logic [1:0] r;
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int k = 0; k < 4; k++) begin
      wr(reset_value_pkg::IDX_PR2, 8'h00);
      wr(reset_value_pkg::IDX_PORT_E_DIRECTION, 8'h00);
      wr(reset_value_pkg::IDX_OPTION, 8'h00);
      wr(reset_value_pkg::IDX_TIMER_TWO_COUNT, 8'hAA);
      wr(reset_value_pkg::IDX_TIMER_ONE_CONTROL, 8'h15);
      wr(reset_value_pkg::IDX_PORT_A_LATCH, 8'h3F);
      wr(reset_value_pkg::IDX_INTERRUPT_CONTROL_REG, 8'h81);
      wr(reset_value_pkg::IDX_STATUS, 8'hE5);
      wr(reset_value_pkg::IDX_PROGRAM_COUNTER_HIGH_LATCH, 8'h1F);
      wr(reset_value_pkg::IDX_PCL, 8'h33);
      pulse(6'h20 >> k);
      chk("pc", 8'h00, program_counter_low);
      chk("event", (k < 2) ? 2'h1 : 2'h2, last_event);
      rc(reset_value_pkg::IDX_PR2, 8'hFF);
      rc(reset_value_pkg::IDX_PORT_E_DIRECTION, 8'h07);
      rc(reset_value_pkg::IDX_OPTION, 8'hFF);
      rc(reset_value_pkg::IDX_TIMER_TWO_COUNT, 8'h00);
      rc(reset_value_pkg::IDX_TIMER_ONE_CONTROL, (k < 2) ? 8'h00 : 8'h15);
      rc(reset_value_pkg::IDX_PORT_A_LATCH, 8'h10);
      rc(reset_value_pkg::IDX_INTERRUPT_CONTROL_REG, 8'h01);
      rc(reset_value_pkg::IDX_STATUS,
         (k == 3) ? 8'h0D : ((k == 2) ? 8'h05 : 8'h1D));
      rc(reset_value_pkg::IDX_PROGRAM_COUNTER_HIGH_LATCH, 8'h00);
    end
    $display("test reset classes done");
    wr(reset_value_pkg::IDX_INTERRUPT_CONTROL_REG, 8'h80);
    wr(reset_value_pkg::IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
    wr(reset_value_pkg::IDX_PERIPHERAL_FLAGS_TWO, 8'h00);
    wr(reset_value_pkg::IDX_PR2, 8'h00);
    wr(reset_value_pkg::IDX_PORT_A_DIRECTION, 8'h00);
    wr(reset_value_pkg::IDX_STATUS, 8'h05);
    sleeping <= 1'b1;
    pc_current <= 8'h20;
    wake_interrupt_control_reg_flags <= 8'h02;
    wake_peripheral_flags_one_flags <= 8'h01;
    wake_peripheral_flags_two_flags <= 8'h04;
    pulse(6'h02);
    chk("pc", 8'h04, program_counter_low);
    chk("event", 2'h3, last_event);
    chk("status", 8'h15, status_reg);
    chk("interrupt_control_reg", 8'h82, interrupt_control_reg);
    chk("period", 8'hFF, timer_two_period);
    rc(reset_value_pkg::IDX_PR2, 8'hFF);
    rc(reset_value_pkg::IDX_PORT_A_DIRECTION, 8'h00);
    rc(reset_value_pkg::IDX_TIMER_TWO_COUNT, 8'h00);
    rc(reset_value_pkg::IDX_INTERRUPT_CONTROL_REG, 8'h82);
    rc(reset_value_pkg::IDX_PERIPHERAL_FLAGS_ONE, 8'h01);
    rc(reset_value_pkg::IDX_PERIPHERAL_FLAGS_TWO, 8'h04);
    rc(reset_value_pkg::IDX_STATUS, 8'h15);
    pulse(6'h01);
    chk("pc", 8'h21, program_counter_low);
    rc(reset_value_pkg::IDX_STATUS, 8'h05);
    wr(reset_value_pkg::IDX_INTERRUPT_CONTROL_REG, 8'h00);
    pulse(6'h02);
    chk("pc", 8'h21, program_counter_low);
    sleeping <= 1'b0;
    $display("test wake-up done");
    for (int i = 0; i < 5; i++) begin
      wr(mi[i], 8'hFF);
      rc(mi[i], me[i]);
    end
    rd(6'h24, d, r);
    chk("rresp", reset_value_pkg::RESP_SLVERR, r);
    chk("rdata", 32'h0, d);
    $display("test masks and unmapped done");
    wrap_up();
  end
endmodule
